// >>> jbi_device.sv
// Device end: test access port, boundary, bypass, identity and indirect registers
`timescale 1ns/1ps
module jbi_device import jbi_pkg::*; #(
  parameter logic [ID_W-1:0] DEVICE_ID = 32'h5a5a_a5a5 // Arbitrary identity value
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Scan link
  jbi_link_if.device link,
  // Core-side capture sources
  input wire logic reset_enable_core,
  input wire logic pullup_enable_core,
  input wire logic [7:0] special_reg_addr,
  input wire logic [7:0] special_reg_data,
  input wire logic [2:0] special_reg_strobes,
  input wire logic [PORT_PINS-1:0] port_oe_core,
  // Pin-side capture sources
  input wire logic rst_pin_in,
  input wire logic crystal_input_pin,
  input wire logic [PORT_PINS-1:0] port_pin_in,
  // Boundary drive values
  output logic rst_enable_drive,
  output logic rst_out_drive,
  output logic pullup_enable_drive,
  output logic [7:0] special_reg_addr_drive,
  output logic [7:0] special_reg_data_drive,
  output logic [2:0] special_reg_strobes_drive,
  output logic [PORT_PINS-1:0] port_oe_drive,
  output logic [PORT_PINS-1:0] port_out_drive,
  output logic force_inputs_high,
  // Indirect register access
  output logic ind_req,
  output logic ind_write,
  output logic [1:0] ind_sel,
  output logic [PAY_W-1:0] write_payload,
  input wire logic ind_ack,
  input wire logic [PAY_W-1:0] read_result
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    jbi_tap_e tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] ir_sh;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BS_LEN-1:0] bs_sh;
    logic [BS_LEN-1:0] bs_upd;
    logic [IND_W-1:0] ind_sh;
    logic busy;
    logic cap_busy;
    logic [PAY_W-1:0] result;
    logic req;
    logic we;
    logic [1:0] sel;
    logic [PAY_W-1:0] payload;
    logic extest;
    logic tdo;
  } jbi_dev_s;
  jbi_dev_s st_q, st_d;
  logic [2:0] lnk_s;
  logic tck_rise, tck_fall;
  logic [PORT_PINS+1:0] pin_s;
  logic [BS_LEN-1:0] cap_vec;
  jbi_dr_e dr_sel;
  logic dr_lsb;
  if (BS_PORT_BASE + 2 * PORT_PINS != BS_LEN) begin : g_chk
    $error("jbi_device: port cells do not fill the boundary chain");
  end
  // Link and pin inputs cross into sys_clk before any logic reads them
  jbi_sync_edge #(.W(3)) u_link_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d({link.tdi, link.tms, link.tck}),
    .q(lnk_s),
    .rise(tck_rise),
    .fall(tck_fall)
  );

  jbi_sync_edge #(.W(PORT_PINS + 2)) u_pin_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d({rst_pin_in, crystal_input_pin, port_pin_in}),
    .q(pin_s),
    .rise(),
    .fall()
  );

  // ****************************************
  // Tap state transitions
  // ****************************************
  function automatic jbi_tap_e tap_next(jbi_tap_e s, logic tms);
    unique case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction

  // ****************************************
  // Boundary capture vector and data register select
  // ****************************************
  always_comb begin
    cap_vec = '0;
    cap_vec[BS_RST_EN] = reset_enable_core;
    cap_vec[BS_RST] = pin_s[PORT_PINS+1];
    cap_vec[BS_XTAL] = pin_s[PORT_PINS];
    cap_vec[BS_PULLUP] = pullup_enable_core;
    cap_vec[BS_ADDR_LSB +: 8] = special_reg_addr;
    cap_vec[BS_DATA_LSB +: 8] = special_reg_data;
    cap_vec[BS_STROBE_LSB +: 3] = special_reg_strobes;
    // Pin p of port k sits at pair 8k+p, enable first then data
    for (int p = 0; p < PORT_PINS; p++) begin
      cap_vec[BS_PORT_BASE + 2 * p] = port_oe_core[p];
      cap_vec[BS_PORT_BASE + 2 * p + 1] = pin_s[p];
    end
  end

  // Unknown codes fall back to bypass, as the standard expects
  always_comb begin
    if (st_q.ir == IR_EXTEST || st_q.ir == IR_SAMPLE) begin
      dr_sel = DR_BS;
    end else if (st_q.ir == IR_IDCODE) begin
      dr_sel = DR_ID;
    end else if (st_q.ir >= IR_FLASH_FIRST && st_q.ir <= IR_FLASH_LAST) begin
      dr_sel = DR_IND;
    end else begin
      dr_sel = DR_BYP;
    end
    unique case (dr_sel)
      DR_BYP: dr_lsb = st_q.byp;
      DR_ID: dr_lsb = st_q.id_sh[0];
      DR_BS: dr_lsb = st_q.bs_sh[0];
      DR_IND: dr_lsb = st_q.ind_sh[0];
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.req = 1'b0;
    // Capture and shift on the rising link clock
    if (tck_rise) begin
      if (st_q.tap == TAP_CAP_IR) begin
        st_d.ir_sh = IR_CAPTURE;
      end
      if (st_q.tap == TAP_SH_IR) begin
        st_d.ir_sh = {lnk_s[2], st_q.ir_sh[IR_W-1:1]};
      end
      if (st_q.tap == TAP_CAP_DR) begin
        if (dr_sel == DR_BYP) st_d.byp = 1'b0;
        if (dr_sel == DR_ID) st_d.id_sh = DEVICE_ID;
        if (dr_sel == DR_BS) st_d.bs_sh = cap_vec;
        if (dr_sel == DR_IND) begin
          st_d.ind_sh = {1'b0, st_q.result, st_q.busy};
          st_d.cap_busy = st_q.busy;
        end
      end
      if (st_q.tap == TAP_SH_DR) begin
        if (dr_sel == DR_BYP) st_d.byp = lnk_s[2];
        if (dr_sel == DR_ID) st_d.id_sh = {lnk_s[2], st_q.id_sh[ID_W-1:1]};
        if (dr_sel == DR_BS) st_d.bs_sh = {lnk_s[2], st_q.bs_sh[BS_LEN-1:1]};
        if (dr_sel == DR_IND) st_d.ind_sh = {lnk_s[2], st_q.ind_sh[IND_W-1:1]};
      end
      st_d.tap = tap_next(st_q.tap, lnk_s[1]);
    end
    // Update and output change on the falling link clock
    if (tck_fall) begin
      if (st_q.tap == TAP_UPD_IR) begin
        st_d.ir = st_q.ir_sh;
        st_d.extest = (st_q.ir_sh == IR_EXTEST);
      end
      if (st_q.tap == TAP_UPD_DR && dr_sel == DR_BS && st_q.ir == IR_EXTEST) begin
        st_d.bs_upd = st_q.bs_sh;
      end
      // Opcode 0x is a poll and leaves everything alone
      if (st_q.tap == TAP_UPD_DR && dr_sel == DR_IND && st_q.ind_sh[OPC_HI] &&
          !st_q.cap_busy && !st_q.busy) begin
        st_d.busy = 1'b1;
        st_d.req = 1'b1;
        st_d.we = st_q.ind_sh[OPC_LO];
        st_d.sel = st_q.ir[1:0] - IR_FLASH_FIRST[1:0];
        st_d.payload = st_q.ind_sh[PAY_W-1:0];
      end
      if (st_q.tap == TAP_SH_DR) begin
        st_d.tdo = dr_lsb;
      end else if (st_q.tap == TAP_SH_IR) begin
        st_d.tdo = st_q.ir_sh[0];
      end
    end
    // Completion: a read returns its right-justified result
    if (ind_ack && st_q.busy) begin
      st_d.busy = 1'b0;
      if (!st_q.we) st_d.result = read_result;
    end
    if (st_q.tap == TAP_RESET) begin
      st_d.ir = IR_IDCODE;
      st_d.extest = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.tap <= TAP_RESET;
      st_q.ir <= IR_IDCODE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs, all straight from state
  // ****************************************
  assign link.tdo = st_q.tdo;
  assign rst_enable_drive = st_q.bs_upd[BS_RST_EN];
  assign rst_out_drive = st_q.bs_upd[BS_RST];
  assign pullup_enable_drive = st_q.bs_upd[BS_PULLUP];
  assign special_reg_addr_drive = st_q.bs_upd[BS_ADDR_LSB +: 8];
  assign special_reg_data_drive = st_q.bs_upd[BS_DATA_LSB +: 8];
  assign special_reg_strobes_drive = st_q.bs_upd[BS_STROBE_LSB +: 3];
  for (genvar p = 0; p < PORT_PINS; p++) begin : g_port
    assign port_oe_drive[p] = st_q.bs_upd[BS_PORT_BASE + 2 * p];
    assign port_out_drive[p] = st_q.bs_upd[BS_PORT_BASE + 2 * p + 1];
  end
  assign force_inputs_high = st_q.extest;
  assign ind_req = st_q.req;
  assign ind_write = st_q.we;
  assign ind_sel = st_q.sel;
  assign write_payload = st_q.payload;
endmodule

// >>> jbi_pkg.sv
// Shared constants and types for the scan link device and host ends
package jbi_pkg;

  // ****************************************
  // Register and path widths
  // ****************************************
  localparam int IR_W = 16;
  localparam int BS_LEN = 87;
  localparam int ID_W = 32;
  localparam int IND_W = 20;
  localparam int PAY_W = 18;
  localparam int PORT_PINS = 32;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [IR_W-1:0] IR_EXTEST = 16'h0000;
  localparam logic [IR_W-1:0] IR_SAMPLE = 16'h0002;
  localparam logic [IR_W-1:0] IR_IDCODE = 16'h0004;
  localparam logic [IR_W-1:0] IR_BYPASS = 16'hffff;
  localparam logic [IR_W-1:0] IR_FLASH_FIRST = 16'h0082;
  localparam logic [IR_W-1:0] IR_FLASH_LAST = 16'h0085;
  localparam logic [IR_W-1:0] IR_CAPTURE = 16'h0001;

  // ****************************************
  // Indirect command and answer layout
  // ****************************************
  localparam int OPC_HI = 19;
  localparam int OPC_LO = 18;
  localparam int RES_LSB = 1;
  localparam int BUSY_BIT = 0;

  // ****************************************
  // Boundary cell positions
  // ****************************************
  localparam int BS_RST_EN = 0;
  localparam int BS_RST = 1;
  localparam int BS_XTAL = 2;
  localparam int BS_PULLUP = 3;
  localparam int BS_ADDR_LSB = 4;
  localparam int BS_DATA_LSB = 12;
  localparam int BS_STROBE_LSB = 20;
  localparam int BS_PORT_BASE = 23;

  // ****************************************
  // Host register map (byte offsets) and fields
  // ****************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam int CMD_LEN_LSB = 0;
  localparam int CMD_IR_BIT = 8;
  localparam int CMD_RST_BIT = 9;
  localparam logic [5:0] MAX_LEN = 6'h20;
  localparam logic [5:0] SEQ_RST = 6'h1f;
  localparam logic [2:0] SEQ_RST_N = 3'h6;
  localparam logic [5:0] SEQ_DR = 6'h01;
  localparam logic [2:0] SEQ_DR_N = 3'h3;
  localparam logic [5:0] SEQ_IR = 6'h03;
  localparam logic [2:0] SEQ_IR_N = 3'h4;
  localparam logic [5:0] SEQ_POST = 6'h01;
  localparam logic [2:0] SEQ_POST_N = 3'h2;

  // ****************************************
  // Test access port states
  // ****************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } jbi_tap_e;

  typedef enum logic [1:0] {DR_BYP, DR_ID, DR_BS, DR_IND} jbi_dr_e;

  typedef enum logic [2:0] {H_IDLE, H_PRE, H_SHIFT, H_POST, H_DONE} jbi_hst_e;

endpackage

// >>> jbi_link_if.sv
// Four-wire scan link between host and device
`timescale 1ns/1ps
interface jbi_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport device (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface

// >>> jbi_sync_edge.sv
// Two-flop synchroniser with edge detect on bit 0
`timescale 1ns/1ps
module jbi_sync_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Asynchronous inputs
  input wire logic [W-1:0] d,
  // Synchronised view
  output logic [W-1:0] q,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic last;
  } jbi_sync_s;

  jbi_sync_s st_q, st_d;

  if (W < 1) begin : g_chk
    $error("jbi_sync_edge: W must be at least 1");
  end

  // Only the second stage is looked at; the first may be metastable
  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.last = st_q.s2[0];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
  assign rise = st_q.s2[0] & ~st_q.last;
  assign fall = ~st_q.s2[0] & st_q.last;
endmodule

// >>> jbi_host.sv
// Host end: APB-controlled scan engine that drives the link clock
`timescale 1ns/1ps
module jbi_host import jbi_pkg::*; #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Scan link
  jbi_link_if.host link
);

  typedef struct packed {
    jbi_hst_e ph;
    logic tck;
    logic tms;
    logic tdi;
    logic [7:0] div;
    logic [5:0] seq;
    logic [2:0] seq_n;
    logic [5:0] len;
    logic [5:0] bits;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } jbi_hst_s;

  localparam logic [7:0] DIV_LOAD = 8'(HALF - 1);

  jbi_hst_s st_q, st_d;
  logic tdo_s;
  logic tick;
  logic setup, access, hit;
  logic [5:0] cmd_len;

  // Half period must cover the device's sampling and tdo return delay
  if (HALF < 8 || HALF > 256) begin : g_chk
    $error("jbi_host: HALF must lie in 8..256");
  end

  jbi_sync_edge #(.W(1)) u_tdo_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(link.tdo),
    .q(tdo_s),
    .rise(),
    .fall()
  );

  assign tick = (st_q.ph != H_IDLE) && (st_q.div == '0);
  assign setup = psel && !penable && !st_q.ready;
  assign access = psel && penable && st_q.ready;
  assign hit = (paddr == REG_CMD) || (paddr == REG_TX) || (paddr == REG_RX) ||
               (paddr == REG_STAT);
  assign cmd_len = pwdata[CMD_LEN_LSB +: 6];

  // ****************************************
  // Bus slave and scan sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    // Read data latched in setup so prdata comes from a flop
    st_d.ready = setup;
    if (setup) begin
      st_d.err = !hit;
      st_d.rdata = '0;
      if (paddr == REG_TX) st_d.rdata = st_q.tx;
      if (paddr == REG_RX) st_d.rdata = st_q.rx;
      if (paddr == REG_STAT) st_d.rdata = {31'h0, st_q.ph != H_IDLE};
    end
    if (access && pwrite && st_q.ph == H_IDLE) begin
      if (paddr == REG_TX) st_d.tx = pwdata;
      // A bad length or a command while busy is dropped
      if (paddr == REG_CMD) begin
        if (pwdata[CMD_RST_BIT]) begin
          st_d.ph = H_PRE;
          st_d.seq = SEQ_RST;
          st_d.seq_n = SEQ_RST_N;
          st_d.len = '0;
        end else if (cmd_len != '0 && cmd_len <= MAX_LEN) begin
          st_d.ph = H_PRE;
          st_d.seq = pwdata[CMD_IR_BIT] ? SEQ_IR : SEQ_DR;
          st_d.seq_n = pwdata[CMD_IR_BIT] ? SEQ_IR_N : SEQ_DR_N;
          st_d.len = cmd_len;
          st_d.bits = cmd_len;
          st_d.rx = '0;
        end
        st_d.tck = 1'b0;
        st_d.tms = st_d.seq[0];
        st_d.div = DIV_LOAD;
      end
    end
    if (st_q.ph != H_IDLE) begin
      st_d.div = tick ? DIV_LOAD : st_q.div - 8'h01;
    end
    // Rising edge: sample tdo and retire the current bit
    if (tick && !st_q.tck) begin
      st_d.tck = 1'b1;
      unique case (st_q.ph)
        H_PRE: begin
          st_d.seq = st_q.seq >> 1;
          st_d.seq_n = st_q.seq_n - 3'h1;
          if (st_q.seq_n == 3'h1) st_d.ph = (st_q.len == '0) ? H_DONE : H_SHIFT;
        end
        H_SHIFT: begin
          st_d.rx = {tdo_s, st_q.rx[31:1]};
          st_d.tx = st_q.tx >> 1;
          st_d.bits = st_q.bits - 6'h01;
          if (st_q.bits == 6'h01) begin
            st_d.ph = H_POST;
            st_d.seq = SEQ_POST;
            st_d.seq_n = SEQ_POST_N;
          end
        end
        H_POST: begin
          st_d.seq = st_q.seq >> 1;
          st_d.seq_n = st_q.seq_n - 3'h1;
          if (st_q.seq_n == 3'h1) st_d.ph = H_DONE;
        end
        default: ;
      endcase
    end
    // Falling edge: present the next tms and tdi
    if (tick && st_q.tck) begin
      st_d.tck = 1'b0;
      if (st_q.ph == H_SHIFT) begin
        st_d.tdi = st_q.tx[0];
        st_d.tms = (st_q.bits == 6'h01);
      end else begin
        st_d.tms = st_q.seq[0];
      end
      // Finished: right-justify what came back from the device
      if (st_q.ph == H_DONE) begin
        st_d.ph = H_IDLE;
        st_d.tms = 1'b0;
        st_d.rx = st_q.rx >> (MAX_LEN - st_q.len);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err & st_q.ready;
  assign link.tck = st_q.tck;
  assign link.tms = st_q.tms;
  assign link.tdi = st_q.tdi;
endmodule

// >>> jbi_asserts.sv
// Timing checker for the scan link wires
`timescale 1ns/1ps
module jbi_asserts #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link wires
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  // ********************
  // Link clock phase counters
  // ********************
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  // Low count saturates, so a long idle gap cannot wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      hi_q <= tck ? hi_q + 8'h01 : 8'h00;
      lo_q <= tck ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
    end
  end
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ********************
  // Properties
  // ********************
  AST_TCK_HIGH: assert property ($fell(tck) |-> hi_q == 8'(HALF))
    else $error("tck high phase length wrong");
  AST_TCK_LOW: assert property ($rose(tck) |-> lo_q >= 8'(HALF))
    else $error("tck low phase too short");
  AST_TMS_HOLD: assert property ((tck && $past(tck)) |-> $stable(tms))
    else $error("tms moved while tck high");
  AST_TDI_HOLD: assert property ($rose(tck) |=> $stable(tdi) [*7])
    else $error("tdi moved while tck high");
  AST_TDO_LOW: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  AST_TDO_LAG: assert property ($changed(tdo) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo moved too soon after tck fall");
  AST_TDO_HOLD: assert property ($rose(tck) |-> $stable(tdo) throughout tck [*4])
    else $error("tdo unstable in high phase");
  AST_RST_IDLE: assert property ($rose(resetn) |-> !tck && !tms && !tdo)
    else $error("link not idle after reset");
  // Main traffic seen
  cover property ($rose(tck) && tms);
  cover property ($changed(tdo));
  cover property ($fell(tck) && tdi);
endmodule

// >>> test_jtag_boundary_and_indirect_access.sv
// Self-checking bench joining the scan host and device ends
`timescale 1ns/1ps
module test_jtag_boundary_and_indirect_access import jbi_pkg::*;;
  localparam logic [31:0] ID_VAL = 32'h7357_9bdf; // Arbitrary identity value
  localparam int HALF_TB = 8;
  typedef struct {logic [15:0] ir; logic [5:0] len; logic [31:0] tx; logic [31:0] ex;} jbi_row_s;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, ind_req, ind_write, fih, wr_q, e;
  logic rst_en_c, pu_c, rst_pin, xtal, rd_en, rd_out, rd_pu;
  logic ind_ack = 1'b0;
  logic [1:0] ind_sel, sel_q;
  logic [2:0] ss, ds;
  logic [7:0] paddr, sa, sd, da, dd;
  logic [17:0] pay, pay_q, wp;
  logic [17:0] regs [4] = '{default: 18'h0};
  logic [31:0] pwdata, prdata, rx, oe_c, pin, doe, dout;
  logic [86:0] cap;
  int lat_q, req_n, n, n0, fail_count, comparisons;
  jbi_row_s rows [3];
  jbi_link_if link ();
  jbi_host #(.HALF(HALF_TB)) i_jbi_host (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  jbi_device #(.DEVICE_ID(ID_VAL)) i_jbi_device (.sys_clk(sys_clk), .resetn(resetn), .link(link),
    .reset_enable_core(rst_en_c), .pullup_enable_core(pu_c), .special_reg_addr(sa),
    .special_reg_data(sd), .special_reg_strobes(ss), .port_oe_core(oe_c), .rst_pin_in(rst_pin),
    .crystal_input_pin(xtal), .port_pin_in(pin), .rst_enable_drive(rd_en), .rst_out_drive(rd_out),
    .pullup_enable_drive(rd_pu), .special_reg_addr_drive(da), .special_reg_data_drive(dd),
    .special_reg_strobes_drive(ds), .port_oe_drive(doe), .port_out_drive(dout),
    .force_inputs_high(fih), .ind_req(ind_req), .ind_write(ind_write), .ind_sel(ind_sel),
    .write_payload(pay), .ind_ack(ind_ack), .read_result(regs[sel_q]));
  jbi_asserts #(.HALF(HALF_TB)) i_jbi_asserts (.sys_clk(sys_clk), .resetn(resetn),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo));
  // Register file on the far side answers late, so busy stays visible across a short scan
  always @(posedge sys_clk) begin
    ind_ack <= 1'b0;
    if (ind_req === 1'b1) begin
      {sel_q, wr_q, pay_q, lat_q} <= {ind_sel, ind_write, pay, 32'd600};
      req_n <= req_n + 1;
    end else if (lat_q > 0) begin
      lat_q <= lat_q - 1;
      ind_ack <= (lat_q == 1);
      if (lat_q == 1 && wr_q) regs[sel_q] <= pay_q;
    end
  end
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Boundary image; bit 2 carries the force flag in the drive view
  function automatic logic [86:0] bs(input logic [3:0] m, input logic [7:0] a, d,
    input logic [2:0] s, input logic [31:0] oe, pv);
    logic [86:0] v;
    v = {64'h0, s, d, a, m};
    for (int p = 0; p < PORT_PINS; p++) begin
      v[23+2*p] = oe[p];
      v[24+2*p] = pv[p];
    end
    return v;
  endfunction
  function automatic logic [86:0] drv();
    return bs({rd_pu, fih, rd_out, rd_en}, da, dd, ds, doe, dout);
  endfunction
  task automatic chk(input string nm, input logic [86:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One bus transfer; the wait ends only on pready or the watchdog
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic er);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {q, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic scan(input logic ir, input logic [5:0] len, input logic [31:0] tx,
    input logic rs = 1'b0);
    logic [31:0] q;
    logic er;
    apb(1'b1, REG_TX, tx, q, er);
    apb(1'b1, REG_CMD, {22'h0, rs, ir, 2'h0, len}, q, er);
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, REG_STAT, 32'h0, q, er);
    apb(1'b0, REG_RX, 32'h0, rx, er);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic setir(input logic [15:0] c);
    scan(1'b1, 6'h10, {16'h0, c});
    chk("ir capture", 87'(IR_CAPTURE), 87'(rx[15:0]));
  endtask
  task automatic poll(input logic [5:0] len, input logic [31:0] tx);
    n = 0;
    do begin
      scan(1'b0, len, tx);
      n++;
    end while (rx[0] !== 1'b0 && n < 40);
    chk("busy bound", 87'h1, 87'(n < 40));
  endtask
  task automatic finish_test();
    $display("TB: %0d comparisons, %0d mismatches", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well beyond the expected run
  initial begin
    #380_000;
    fail_count++;
    finish_test();
  end
  // ********************
  // Main sequence
  // ********************
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rst_en_c, rst_pin, xtal, pu_c, sa, sd, ss} = {4'b1010, 8'h5a, 8'hc3, 3'b101};
    {oe_c, pin} = {32'h3c5a_0f96, 32'h9e21_c3a5};
    cap = bs({pu_c, xtal, rst_pin, rst_en_c}, sa, sd, ss, oe_c, pin);
    rows[0] = '{IR_IDCODE, 6'h20, 32'h0, ID_VAL};
    rows[1] = '{IR_BYPASS, 6'h08, 32'ha5, 32'h4a};
    rows[2] = '{IR_SAMPLE, 6'h20, 32'hffff_ffff, cap[31:0]};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    apb(1'b0, REG_STAT, 32'h0, rx, e);
    chk("stat", 87'h0, 87'({rx, e}));
    apb(1'b0, 8'h10, 32'h0, rx, e);
    chk("unmapped", 87'h1, 87'({rx, e}));
    chk("reset drives", 87'h0, drv());
    $display("TB: test reset done");
    scan(1'b0, 6'h00, 32'h0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      setir(rows[i].ir);
      scan(1'b0, rows[i].len, rows[i].tx);
      chk("dr out", 87'(rows[i].ex), 87'(rx & 32'((64'h1 << rows[i].len) - 64'h1)));
    end
    chk("sample drives", 87'h0, drv());
    $display("TB: test rows done");
    setir(IR_EXTEST);
    chk("extest force", 87'h4, drv());
    scan(1'b0, 6'h20, 32'hc3a5_5a3c);
    chk("extest capture", 87'(cap[31:0]), 87'(rx));
    chk("extest update", {32'hc3a5_5a3c, cap[86:32]} | 87'h4, drv());
    setir(IR_BYPASS);
    chk("drives kept", {32'hc3a5_5a3c, cap[86:32]} & ~87'h4, drv());
    $display("TB: test extest done");
    // Reset in mid-run clears the drives and restores the identity instruction
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    chk("rerun drives", 87'h0, drv());
    scan(1'b0, 6'h00, 32'h0, 1'b1);
    scan(1'b0, 6'h20, 32'h0);
    chk("rerun ident", 87'(ID_VAL), 87'(rx));
    setir(IR_FLASH_FIRST);
    n0 = req_n;
    scan(1'b0, 6'h02, 32'h1);
    chk("poll code", 87'h0, 87'(req_n - n0));
    for (int k = 0; k < 4; k++) begin
      wp = {16'ha5c3, 2'(k)};
      setir(IR_FLASH_FIRST + 16'(k));
      n0 = req_n;
      scan(1'b0, 6'h14, {12'h0, 2'b11, wp});
      chk("idle busy", 87'h0, 87'(rx[0]));
      chk("write req", 87'({32'd1, 2'(k), 1'b1, wp}), 87'({req_n - n0, sel_q, wr_q, pay_q}));
      poll(6'h02, 32'h2);
      chk("busy refusal", 87'h1, 87'(n > 1));
      chk("read start", 87'({32'd2, 1'b0}), 87'({req_n - n0, wr_q}));
      poll(6'h01, 32'h0);
      scan(1'b0, 6'h14, 32'h0);
      chk("read back", 87'({1'b0, wp, 1'b0}), 87'(rx[19:0]));
    end
    $display("TB: test indirect done");
    finish_test();
  end
endmodule
